// ### inc/ringer_pkg.sv
// Behaviour
// - Tones are produced only while the supply check passes and, except with the band select tied high, the ringing-frequency check passes.
// - With the band select open, ringing periods of 23 Hz to 54 Hz are accepted.
// - With the band select tied low, ringing periods of 12 Hz to 54 Hz are accepted.
// - With the band select tied high, the frequency check is ignored and the supply alone starts tones.
// - The supply check turns on when the rectified supply reaches the turn-on level near 6 V.
// - The supply check turns off only when the supply falls to the turn-off level near 3 V.
// - The tone-step repetition rate is the sweep oscillator rate divided by 32; the three-tone cycle repeats at that rate divided by 3.
// - The three tones are the main clock divided by 560, 420 and 336.
// - Every start of the tone sequence begins with the lowest tone.
// - The sequence stops as soon as the supply reaches turn-off or, except with the band select tied high, the ringing leaves the band.
// - The two tone outputs are complementary square waves for a bridge load.
// - With pulse-width select open each pulse is cut to 0.2 ms; tied low the full pulse is kept.
// - The load-switch output is high while the conditions are unmet and low once both are met.
package ringer_pkg;
  // ----------------------------------------
  // clocks
  // ----------------------------------------
  localparam int REF_CLK_HZ = 250_000_000;
  localparam int MAIN_CLK_HZ = 455_000;
  localparam int MAIN_DIV_INT = REF_CLK_HZ / MAIN_CLK_HZ;
  localparam int MAIN_DIV_W = 10;
  localparam logic [MAIN_DIV_W-1:0] MAIN_DIV = MAIN_DIV_W'(MAIN_DIV_INT);

  // ----------------------------------------
  // tones and sequencer
  // ----------------------------------------
  localparam int TONE_DIV_LOW = 560;
  localparam int TONE_DIV_MID = 420;
  localparam int TONE_DIV_HIGH = 336;
  localparam int HALF_W = 9;
  localparam int STEP_SWEEPS = 32;
  localparam int SWEEP_W = 5;
  localparam logic [SWEEP_W-1:0] SWEEP_LAST = SWEEP_W'(STEP_SWEEPS - 1);

  typedef enum logic [1:0] {TONE_LOW, TONE_MID, TONE_HIGH} tone_t;

  // ----------------------------------------
  // ringing band, periods in main clock cycles
  // ----------------------------------------
  localparam int PERIOD_W = 16;
  localparam int BAND_MAX_HZ = 54;
  localparam int BAND_MIN_WIDE_HZ = 23;
  localparam int BAND_MIN_LOW_HZ = 12;
  localparam logic [PERIOD_W-1:0] PERIOD_MIN = PERIOD_W'(MAIN_CLK_HZ / BAND_MAX_HZ);
  localparam logic [PERIOD_W-1:0] PERIOD_MAX_WIDE = PERIOD_W'(MAIN_CLK_HZ / BAND_MIN_WIDE_HZ);
  localparam logic [PERIOD_W-1:0] PERIOD_MAX_LOW = PERIOD_W'(MAIN_CLK_HZ / BAND_MIN_LOW_HZ);
  localparam logic [PERIOD_W-1:0] PERIOD_SAT = 16'hFFFF;

  typedef enum logic [1:0] {BAND_WIDE, BAND_LOW, BAND_DC} band_t;

  // ----------------------------------------
  // pulse width limit
  // ----------------------------------------
  localparam int PULSE_LIMIT_NS = 200_000;
  localparam int PULSE_LIMIT_CYC = (PULSE_LIMIT_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PULSE_W = 16;

  function automatic logic rising(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction : rising

  function automatic logic [HALF_W-1:0] tone_half(input tone_t t);
    unique case (t)
      TONE_LOW: return HALF_W'(TONE_DIV_LOW / 2);
      TONE_MID: return HALF_W'(TONE_DIV_MID / 2);
      TONE_HIGH: return HALF_W'(TONE_DIV_HIGH / 2);
      default: return HALF_W'(TONE_DIV_LOW / 2);
    endcase
  endfunction : tone_half

  function automatic tone_t tone_succ(input tone_t t);
    unique case (t)
      TONE_LOW: return TONE_MID;
      TONE_MID: return TONE_HIGH;
      TONE_HIGH: return TONE_LOW;
      default: return TONE_LOW;
    endcase
  endfunction : tone_succ
endpackage : ringer_pkg

// ### design/tone_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tone_divider (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // control
  input wire logic main_tick,
  input wire logic restart,
  input wire logic [ringer_pkg::HALF_W-1:0] half_period,
  // square wave
  output logic phase,
  output logic flip
);
  import ringer_pkg::*;

  logic [HALF_W-1:0] cnt;
  logic [HALF_W-1:0] next_cnt;
  logic next_phase;
  logic next_flip;

  always_comb begin
    next_cnt = cnt;
    next_phase = phase;
    next_flip = 1'b0;
    if (restart) begin
      next_cnt = '0;
      next_phase = 1'b0;
    end else if (main_tick) begin
      // >= so a shorter half period after a tone change never overruns
      if (cnt >= half_period - HALF_W'(1)) begin
        next_cnt = '0;
        next_phase = ~phase;
        next_flip = 1'b1;
      end else begin
        next_cnt = cnt + HALF_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      phase <= 1'b0;
      flip <= 1'b0;
    end else begin
      cnt <= next_cnt;
      phase <= next_phase;
      flip <= next_flip;
    end
  end
endmodule : tone_divider
`default_nettype wire

// ### design/three_tone_ringer_control.sv
`timescale 1ns/1ps
`default_nettype none
module three_tone_ringer_control #(
  parameter logic [ringer_pkg::PULSE_W-1:0] PULSE_CYC = ringer_pkg::PULSE_W'(ringer_pkg::PULSE_LIMIT_CYC)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // ringing and supply sense
  input wire logic ring_in,
  input wire logic supply_on_level,
  input wire logic supply_off_level,
  input wire logic sweep_osc,
  // option straps
  input wire ringer_pkg::band_t band_sel,
  input wire logic pw_limit,
  // outputs
  output logic tone_p,
  output logic tone_n,
  output logic load_sw,
  output logic tone_active,
  output ringer_pkg::tone_t tone_step
);
  import ringer_pkg::*;

  // ----------------------------------------
  // main clock enable
  // ----------------------------------------
  logic [MAIN_DIV_W-1:0] main_cnt;
  logic [MAIN_DIV_W-1:0] next_main_cnt;
  logic main_tick;
  logic next_main_tick;

  always_comb begin
    next_main_tick = 1'b0;
    next_main_cnt = main_cnt + MAIN_DIV_W'(1);
    if (main_cnt == MAIN_DIV - MAIN_DIV_W'(1)) begin
      next_main_cnt = '0;
      next_main_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      main_cnt <= '0;
      main_tick <= 1'b0;
    end else begin
      main_cnt <= next_main_cnt;
      main_tick <= next_main_tick;
    end
  end

  // ----------------------------------------
  // ringing frequency check
  // ----------------------------------------
  logic ring_prev;
  logic [PERIOD_W-1:0] period_cnt;
  logic [PERIOD_W-1:0] next_period_cnt;
  logic freq_ok;
  logic next_freq_ok;
  logic [PERIOD_W-1:0] period_max;

  always_comb begin
    // an illegal select code falls back to the wide band
    period_max = (band_sel == BAND_LOW) ? PERIOD_MAX_LOW : PERIOD_MAX_WIDE;
    next_period_cnt = period_cnt;
    next_freq_ok = freq_ok;
    if (rising(ring_prev, ring_in)) begin
      // period measured in main clock cycles against band edges
      next_freq_ok = (period_cnt >= PERIOD_MIN) && (period_cnt <= period_max);
      next_period_cnt = '0;
    end else begin
      if (main_tick && period_cnt != PERIOD_SAT) begin
        next_period_cnt = period_cnt + PERIOD_W'(1);
      end
      // ringing lost or too slow: drop at once instead of waiting for an edge
      if (period_cnt > period_max) begin
        next_freq_ok = 1'b0;
      end
    end
  end

  // counter starts saturated so the first edge after reset never passes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ring_prev <= 1'b0;
      period_cnt <= PERIOD_SAT;
      freq_ok <= 1'b0;
    end else begin
      ring_prev <= ring_in;
      period_cnt <= next_period_cnt;
      freq_ok <= next_freq_ok;
    end
  end

  // ----------------------------------------
  // supply level hysteresis
  // ----------------------------------------
  logic supply_ok;
  logic next_supply_ok;

  always_comb begin
    if (supply_ok) begin
      next_supply_ok = supply_off_level;
    end else begin
      next_supply_ok = supply_on_level;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      supply_ok <= 1'b0;
    end else begin
      supply_ok <= next_supply_ok;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic cond;
  logic active;
  logic next_active;
  logic sweep_prev;
  logic [SWEEP_W-1:0] sweep_cnt;
  logic [SWEEP_W-1:0] next_sweep_cnt;
  tone_t tone;
  tone_t next_tone;

  always_comb begin
    cond = supply_ok && ((band_sel == BAND_DC) || freq_ok);
    next_active = cond;
    next_sweep_cnt = sweep_cnt;
    next_tone = tone;
    if (!active) begin
      next_sweep_cnt = '0;
      next_tone = TONE_LOW;
    end else if (rising(sweep_prev, sweep_osc)) begin
      if (sweep_cnt == SWEEP_LAST) begin
        next_sweep_cnt = '0;
        next_tone = tone_succ(tone);
      end else begin
        next_sweep_cnt = sweep_cnt + SWEEP_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      active <= 1'b0;
      sweep_prev <= 1'b0;
      sweep_cnt <= '0;
      tone <= TONE_LOW;
    end else begin
      active <= next_active;
      sweep_prev <= sweep_osc;
      sweep_cnt <= next_sweep_cnt;
      tone <= next_tone;
    end
  end

  // ----------------------------------------
  // tone generation and output stage
  // ----------------------------------------
  logic phase;
  logic flip;
  logic [PULSE_W-1:0] pulse_cnt;
  logic [PULSE_W-1:0] next_pulse_cnt;
  logic limit_ok;
  logic next_tone_p;
  logic next_tone_n;

  tone_divider u_div (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .main_tick(main_tick),
    .restart(~active),
    .half_period(tone_half(tone)),
    .phase(phase),
    .flip(flip)
  );

  always_comb begin
    next_pulse_cnt = pulse_cnt;
    if (!active || flip) begin
      next_pulse_cnt = '0;
    end else if (pulse_cnt != PULSE_CYC) begin
      next_pulse_cnt = pulse_cnt + PULSE_W'(1);
    end
    // both legs low once the limit runs out: no drive into the load
    limit_ok = !pw_limit || (pulse_cnt < PULSE_CYC);
    next_tone_p = active && phase && limit_ok;
    next_tone_n = active && !phase && limit_ok;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_cnt <= '0;
      tone_p <= 1'b0;
      tone_n <= 1'b0;
      load_sw <= 1'b1;
      tone_active <= 1'b0;
      tone_step <= TONE_LOW;
    end else begin
      pulse_cnt <= next_pulse_cnt;
      tone_p <= next_tone_p;
      tone_n <= next_tone_n;
      load_sw <= ~cond;
      tone_active <= active;
      tone_step <= tone;
    end
  end
endmodule : three_tone_ringer_control
`default_nettype wire

// ### dv/ringer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ringer_monitor #(
  parameter logic [ringer_pkg::PULSE_W-1:0] PULSE_CYC = ringer_pkg::PULSE_W'(ringer_pkg::PULSE_LIMIT_CYC)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // sense and straps
  input wire logic supply_on_level,
  input wire logic supply_off_level,
  input wire ringer_pkg::band_t band_sel,
  input wire logic pw_limit,
  // outputs
  input wire logic tone_p,
  input wire logic tone_n,
  input wire logic load_sw,
  input wire logic tone_active,
  input wire ringer_pkg::tone_t tone_step
);
  import ringer_pkg::*;
  // run length of a driven leg, so a missing truncation shows up
  logic [15:0] hi_cnt;
  logic [15:0] next_hi_cnt;
  always_comb begin
    next_hi_cnt = (tone_p || tone_n) ? hi_cnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt <= 16'h0000;
    end else begin
      hi_cnt <= next_hi_cnt;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_dc_held;
    (band_sel == BAND_DC && supply_on_level && supply_off_level) [*4];
  endsequence
  a_legs_apart: assert property (!(tone_p && tone_n))
    else $error("both bridge legs high");
  a_load_pair: assert property (tone_active == !$past(load_sw))
    else $error("load switch out of step with tone activity");
  a_quiet_idle: assert property (!tone_active |-> !tone_p && !tone_n)
    else $error("leg driven while idle");
  a_start_low: assert property ($rose(tone_active) |-> tone_step == TONE_LOW)
    else $error("sequence did not start on low tone");
  a_step_order: assert property (tone_active && !load_sw && !$past(load_sw) &&
    tone_step != $past(tone_step) |-> tone_step == (($past(tone_step) == TONE_HIGH) ?
    TONE_LOW : tone_t'($past(tone_step) + 2'h1)))
    else $error("tone step out of order");
  a_supply_drop: assert property (!supply_off_level |-> ##[1:3] load_sw)
    else $error("tones kept after supply drop");
  a_dc_start: assert property (s_dc_held |-> !load_sw)
    else $error("dc strap did not start tones");
  a_pulse_cap: assert property (pw_limit |-> hi_cnt <= PULSE_CYC)
    else $error("pulse longer than limit");
endmodule : ringer_monitor
`default_nettype wire

// ### dv/sweep_source.sv
`timescale 1ns/1ps
`default_nettype none
module sweep_source (
  // clock
  input wire logic ref_clk,
  // total rising edges requested so far
  input wire logic [7:0] want,
  // oscillator
  output logic sweep_osc,
  output logic [7:0] rises
);
  // the rc oscillator rests low once the requested edges are given
  initial begin
    sweep_osc = 1'b0;
    rises = 8'h00;
  end
  always @(negedge ref_clk) begin
    if (sweep_osc) begin
      sweep_osc <= 1'b0;
    end else if (rises != want) begin
      sweep_osc <= 1'b1;
      rises <= rises + 8'h01;
    end
  end
endmodule : sweep_source
`default_nettype wire

// ### dv/three_tone_ringer_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module three_tone_ringer_control_tb;
  import ringer_pkg::*;
  localparam logic [PULSE_W-1:0] PCYC = 16'h0014;
  logic ref_clk, rstn, ring_in, supply_on_level, supply_off_level, pw_limit;
  logic sweep_osc, tone_p, tone_n, load_sw, tone_active;
  band_t band_sel;
  tone_t tone_step;
  logic [7:0] want, rises;
  int fails, compares;
  band_t bands[2] = '{BAND_WIDE, BAND_LOW};
  int steps[5] = '{31, 1, 32, 32, 32};
  tone_t exp_step[5] = '{TONE_LOW, TONE_MID, TONE_HIGH, TONE_LOW, TONE_MID};
  three_tone_ringer_control #(.PULSE_CYC(PCYC)) i_three_tone_ringer_control (
    .ref_clk(ref_clk), .rstn(rstn), .ring_in(ring_in), .supply_on_level(supply_on_level),
    .supply_off_level(supply_off_level), .sweep_osc(sweep_osc), .band_sel(band_sel),
    .pw_limit(pw_limit), .tone_p(tone_p), .tone_n(tone_n), .load_sw(load_sw),
    .tone_active(tone_active), .tone_step(tone_step));
  sweep_source i_sweep_source (.ref_clk(ref_clk), .want(want), .sweep_osc(sweep_osc),
    .rises(rises));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one compare covers {load_sw, tone_active, tone_p, tone_n, tone_step}
  task automatic outs(input logic [15:0] exp);
    check("outputs", {10'h000, load_sw, tone_active, tone_p, tone_n, tone_step}, exp);
  endtask : outs
  task automatic drive(input band_t b, input logic on, input logic off);
    band_sel = b;
    supply_on_level = on;
    supply_off_level = off;
    repeat (6) @(negedge ref_clk);
  endtask : drive
  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    stop_test();
  end
  initial begin
    {rstn, ring_in, supply_on_level, supply_off_level, pw_limit} = 5'h00;
    band_sel = BAND_WIDE;
    want = 8'h00;
    fails = 0;
    compares = 0;
    repeat (10) @(negedge ref_clk);
    outs(16'h0020);
    rstn = 1'b1;
    $display("test reset done");
    // fast ringing, first edge always rejected: stays silent
    foreach (bands[i]) begin
      drive(bands[i], 1'b1, 1'b1);
      repeat (2) begin
        ring_in = 1'b1;
        repeat (3) @(negedge ref_clk);
        ring_in = 1'b0;
        repeat (3) @(negedge ref_clk);
      end
      outs(16'h0020);
    end
    $display("test band gate done");
    drive(BAND_DC, 1'b1, 1'b1);
    outs(16'h0014);
    drive(BAND_DC, 1'b0, 1'b1);
    outs(16'h0014);
    drive(BAND_DC, 1'b0, 1'b0);
    outs(16'h0020);
    drive(BAND_DC, 1'b0, 1'b1);
    outs(16'h0020);
    $display("test supply hysteresis done");
    drive(BAND_DC, 1'b1, 1'b1);
    foreach (steps[i]) begin
      want <= want + 8'(steps[i]);
      repeat (2 * steps[i] + 6) @(negedge ref_clk);
      check("tone step", 16'(tone_step), 16'(exp_step[i]));
    end
    drive(BAND_DC, 1'b0, 1'b0);
    drive(BAND_DC, 1'b1, 1'b1);
    check("restart step", 16'(tone_step), 16'(TONE_LOW));
    $display("test sequencer done");
    drive(BAND_DC, 1'b0, 1'b0);
    pw_limit = 1'b1;
    drive(BAND_DC, 1'b1, 1'b1);
    outs(16'h0014);
    repeat (24) @(negedge ref_clk);
    outs(16'h0010);
    $display("test pulse limit done");
    stop_test();
  end
endmodule : three_tone_ringer_control_tb
bind three_tone_ringer_control ringer_monitor #(.PULSE_CYC(PULSE_CYC)) i_ringer_monitor (
  .ref_clk(ref_clk), .rstn(rstn), .supply_on_level(supply_on_level),
  .supply_off_level(supply_off_level), .band_sel(band_sel), .pw_limit(pw_limit),
  .tone_p(tone_p), .tone_n(tone_n), .load_sw(load_sw), .tone_active(tone_active),
  .tone_step(tone_step));
`default_nettype wire
